// ==== core/pvp_port.v ====
// Notes on behaviour
// - One port clock, three syncs, sixteen data
// - Each frame sync may be input or output
// - General mode moves words one direction
// - Video mode moves 8 or 10 bit samples
// - Port finds line and field codes itself
// - Input, frame capture and output submodes
// - Wait programmed delay before first sample
// - Capture exactly count samples per sync
// - Word width 8 or 10 to 16
// - Capture drives line and field syncs
// - Output drives data with generated syncs
// - Active mode drops blanking and VBI lines
// - Active mode never forwards timing codes
// - After field start, drop until SAV
// - Active mode count means lines per frame
// - Blanking mode forwards only VBI samples
// - Entire field mode forwards every sample
// - Entire field starts right after alignment
`timescale 1ns/1ps
`include "pvp_regs.vh"

module pvp_port #(
    parameter DW = 16
) (
    // Clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // Register bus
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // Port pins
    input  wire          port_input_clock,
    input  wire          frame_sync_one_in,
    output reg           frame_sync_one_out,
    output reg           frame_sync_one_oe,
    input  wire          frame_sync_two_in,
    output reg           frame_sync_two_out,
    output reg           frame_sync_two_oe,
    input  wire          frame_sync_three_in,
    output reg           frame_sync_three_out,
    output reg           frame_sync_three_oe,
    input  wire [DW-1:0] data_in,
    output reg  [DW-1:0] data_out,
    output reg           data_oe,
    // Captured words toward memory
    output reg  [DW-1:0] rx_tdata,
    output reg           rx_tvalid,
    input  wire          rx_tready,
    // Words from memory to send
    input  wire [DW-1:0] tx_tdata,
    input  wire          tx_tvalid,
    output reg           tx_tready
);

    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_XFER = 3'b100;

    // Registers
    reg  [`PVP_CTRL_W-1:0] port_control_setting;
    reg  [15:0]            start_delay_setting;
    reg  [15:0]            transfer_count_setting;
    reg  [15:0]            line_len;
    reg  [15:0]            frame_lines;
    reg                    st_ovr;
    reg                    st_udr;
    reg                    st_done;

    wire       en   = port_control_setting[`PVP_CTRL_EN];
    wire [1:0] sub  = port_control_setting[`PVP_CTRL_SUB+1:`PVP_CTRL_SUB];
    wire       itu  = port_control_setting[`PVP_CTRL_ITU];
    wire [1:0] itum = port_control_setting[`PVP_CTRL_ITUM+1:`PVP_CTRL_ITUM];
    wire [2:0] dlen = port_control_setting[`PVP_CTRL_DLEN+2:`PVP_CTRL_DLEN];
    wire [1:0] nfs  = port_control_setting[`PVP_CTRL_NFS+1:`PVP_CTRL_NFS];

    // Pin synchronisers; only stage two and later feed logic
    reg  [2:0]    clk_s;
    reg  [2:0]    fs_m;
    reg  [2:0]    fs_q;
    reg  [DW-1:0] d_m;
    reg  [DW-1:0] d_q;
    reg           fs1_last;

    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_s <= 3'h0;
            fs_m  <= 3'h0;
            fs_q  <= 3'h0;
            d_m   <= {DW{1'b0}};
            d_q   <= {DW{1'b0}};
        end else begin
            clk_s <= {clk_s[1:0], port_input_clock};
            fs_m  <= {frame_sync_three_in, frame_sync_two_in,
                      frame_sync_one_in};
            fs_q  <= fs_m;
            d_m   <= data_in;
            d_q   <= d_m;
        end
    end

    // One enable per rising port clock edge; the partner keeps it slow
    wire pclk_en = clk_s[1] & ~clk_s[2];

    // Word width mask
    wire [4:0]    width = (dlen == 3'h0) ? 5'd8 : 5'd9 + {2'h0, dlen};
    wire [DW-1:0] wmask = {DW{1'b1}} >> (DW - width);
    wire [DW-1:0] word_in = d_q & wmask;

    wire gp_run  = en & ~itu;
    wire gen_on  = gp_run & (sub != `PVP_SUB_IN);
    wire out_on  = gp_run & (sub == `PVP_SUB_OUT);
    wire itu_run = en & itu;

    // Sync generator for frame capture and output
    reg  [15:0] hcnt;
    reg  [15:0] vcnt;
    wire        line_start = gen_on & pclk_en & (hcnt == 16'h0);

    always @(posedge aclk) begin
        if (!aresetn || !gen_on) begin
            hcnt                 <= 16'h0;
            vcnt                 <= 16'h0;
            frame_sync_one_out   <= 1'b0;
            frame_sync_two_out   <= 1'b0;
            frame_sync_three_out <= 1'b0;
        end else if (pclk_en) begin
            if (hcnt + 16'h1 >= line_len) begin
                hcnt <= 16'h0;
                if (vcnt + 16'h1 >= frame_lines)
                    vcnt <= 16'h0;
                else
                    vcnt <= vcnt + 16'h1;
            end else begin
                hcnt <= hcnt + 16'h1;
            end
            frame_sync_one_out   <= (hcnt == 16'h0);
            frame_sync_two_out   <= (vcnt == 16'h0);
            frame_sync_three_out <= (hcnt == 16'h0) & (vcnt == 16'h0);
        end
    end

    // Sync directions follow the submode and the number of syncs
    always @(posedge aclk) begin
        if (!aresetn) begin
            frame_sync_one_oe   <= 1'b0;
            frame_sync_two_oe   <= 1'b0;
            frame_sync_three_oe <= 1'b0;
            data_oe             <= 1'b0;
        end else begin
            frame_sync_one_oe   <= gen_on;
            frame_sync_two_oe   <= gen_on & ((sub == `PVP_SUB_CAP) |
                                   (nfs >= 2'h2));
            frame_sync_three_oe <= out_on & (nfs == 2'h3);
            data_oe             <= out_on;
        end
    end

    // General-purpose transfer sequencer
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] dcnt;
    reg  [15:0] xcnt;
    wire        fs1_rise = pclk_en & fs_q[0] & ~fs1_last;
    wire        trig = gp_run & ((sub == `PVP_SUB_IN) ? fs1_rise
                                                      : line_start);
    wire        xfer_tick = (state == ST_XFER) & pclk_en;
    wire        last_word = xfer_tick & (xcnt <= 16'h1);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trig && transfer_count_setting != 16'h0) begin
                    if (start_delay_setting == 16'h0)
                        next_state = ST_XFER;
                    else
                        next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (pclk_en && dcnt <= 16'h1)
                    next_state = ST_XFER;
            end
            ST_XFER: begin
                if (last_word)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn || !gp_run) begin
            state    <= ST_IDLE;
            dcnt     <= 16'h0;
            xcnt     <= 16'h0;
            fs1_last <= 1'b0;
        end else begin
            state <= next_state;
            if (pclk_en)
                fs1_last <= fs_q[0];
            if (state == ST_IDLE) begin
                dcnt <= start_delay_setting;
                xcnt <= transfer_count_setting;
            end else if (state == ST_WAIT && pclk_en) begin
                dcnt <= dcnt - 16'h1;
            end else if (xfer_tick) begin
                xcnt <= xcnt - 16'h1;
            end
        end
    end

    // Video timing code detector
    wire       itu10 = (dlen != 3'h0);
    wire [9:0] smp   = itu10 ? d_q[9:0] : {2'h0, d_q[7:0]};
    wire       s_one = itu10 ? (smp == 10'h3ff) : (smp[7:0] == 8'hff);
    wire       s_zero = (smp == 10'h000);
    wire [7:0] xy    = itu10 ? smp[9:2] : smp[7:0];
    reg  [1:0] pre_st;
    wire       itu_tick = itu_run & pclk_en;
    wire       is_xy = itu_tick & (pre_st == 2'h3);
    wire       f_bit = xy[6];
    wire       v_bit = xy[5];
    wire       h_bit = xy[4];
    reg        last_f;
    reg        aligned;
    reg        act;
    reg        in_vbi;
    reg  [15:0] lines_left;

    always @(posedge aclk) begin
        if (!aresetn || !itu_run) begin
            pre_st     <= 2'h0;
            last_f     <= 1'b1;
            aligned    <= 1'b0;
            act        <= 1'b0;
            in_vbi     <= 1'b0;
            lines_left <= 16'h0;
        end else if (itu_tick) begin
            if (s_one)
                pre_st <= 2'h1;
            else if (s_zero && (pre_st == 2'h1 || pre_st == 2'h2))
                pre_st <= pre_st + 2'h1;
            else
                pre_st <= 2'h0;
            if (is_xy) begin
                last_f <= f_bit;
                in_vbi <= v_bit;
                if (!aligned && !f_bit && last_f) begin
                    aligned    <= 1'b1;
                    act        <= 1'b0;
                    lines_left <= transfer_count_setting;
                end else if (aligned) begin
                    if (!h_bit && !v_bit) begin
                        act <= 1'b1;
                    end else if (h_bit) begin
                        act <= 1'b0;
                        if (act && itum == `PVP_ITU_ACT) begin
                            lines_left <= lines_left - 16'h1;
                            if (lines_left <= 16'h1)
                                aligned <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Four-deep sample line so a timing code can be withdrawn
    reg  [4*DW-1:0] pipe_d;
    reg  [3:0]      pipe_k;
    reg             keep_new;
    wire            drop_codes = (itum != `PVP_ITU_FULL);
    wire            itu_word = itu_tick & pipe_k[3];

    always @* begin
        case (itum)
            `PVP_ITU_ACT:  keep_new = aligned & act & ~in_vbi;
            `PVP_ITU_VBI:  keep_new = aligned & in_vbi;
            `PVP_ITU_FULL: keep_new = aligned;
            default:       keep_new = 1'b0;
        endcase
        if (is_xy && drop_codes)
            keep_new = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn || !itu_run) begin
            pipe_d <= {(4*DW){1'b0}};
            pipe_k <= 4'h0;
        end else if (itu_tick) begin
            pipe_d <= {pipe_d[3*DW-1:0], {(DW-10){1'b0}}, smp};
            pipe_k <= {pipe_k[2:0] & ~{3{is_xy & drop_codes}},
                       keep_new};
        end
    end

    // Memory-side stream toward the processor
    wire          gp_word = xfer_tick & ~out_on;
    wire          word_ev = gp_word | itu_word;
    wire [DW-1:0] word_val = itu_run ? pipe_d[4*DW-1:3*DW] : word_in;
    wire          set_ovr = word_ev & rx_tvalid & ~rx_tready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_tvalid <= 1'b0;
            rx_tdata  <= {DW{1'b0}};
        end else if (word_ev && !set_ovr) begin
            rx_tvalid <= 1'b1;
            rx_tdata  <= word_val;
        end else if (rx_tready) begin
            rx_tvalid <= 1'b0;
        end
    end

    // Word to send; one held word, refilled as soon as it is used
    reg           tx_have;
    reg  [DW-1:0] tx_hold;
    wire          tx_take = tx_tvalid & tx_tready;
    wire          tx_use = xfer_tick & out_on & tx_have;
    wire          set_udr = xfer_tick & out_on & ~tx_have;
    wire          next_have = (tx_have & ~tx_use) | tx_take;

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_have   <= 1'b0;
            tx_hold   <= {DW{1'b0}};
            tx_tready <= 1'b0;
            data_out  <= {DW{1'b0}};
        end else begin
            tx_have   <= next_have & out_on;
            tx_tready <= out_on & ~next_have;
            if (tx_take)
                tx_hold <= tx_tdata & wmask;
            if (tx_use)
                data_out <= tx_hold;
        end
    end

    wire set_done = last_word | (itu_tick & is_xy & aligned & h_bit &
                    act & (itum == `PVP_ITU_ACT) & (lines_left <= 16'h1));

    // Register bus slave, one write and one read at a time
    reg  [7:0]  aw_addr;
    reg         aw_got;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_got;
    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take = s_axi_wvalid & s_axi_wready;
    wire        ar_take = s_axi_arvalid & s_axi_arready;
    wire        do_wr = aw_got & w_got & ~s_axi_bvalid;
    wire        wr_hit = (aw_addr <= `PVP_OFF_FRAME) & (aw_addr[1:0] == 2'h0);
    wire        wr_stat = do_wr & (aw_addr == `PVP_OFF_STAT) & w_strb[0];
    wire [15:0] wlo = w_data[15:0];

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? nw[15:8] : old[15:8],
                       strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    wire [15:0] ctrl_new = merge16({5'h00, port_control_setting}, wlo,
                                   w_strb[1:0]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PVP_RESP_OKAY;
            port_control_setting   <= `PVP_RST_CTRL;
            start_delay_setting    <= `PVP_RST_DELAY;
            transfer_count_setting <= `PVP_RST_COUNT;
            line_len      <= `PVP_RST_LINE;
            frame_lines   <= `PVP_RST_FRAME;
        end else begin
            s_axi_awready <= ~(aw_got | aw_take) & ~do_wr;
            s_axi_wready  <= ~(w_got | w_take) & ~do_wr;
            if (aw_take) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PVP_RESP_OKAY : `PVP_RESP_SLVERR;
                case (aw_addr)
                    `PVP_OFF_CTRL: port_control_setting <=
                        ctrl_new[`PVP_CTRL_W-1:0];
                    `PVP_OFF_DELAY: start_delay_setting <=
                        merge16(start_delay_setting, wlo, w_strb[1:0]);
                    `PVP_OFF_COUNT: transfer_count_setting <=
                        merge16(transfer_count_setting, wlo, w_strb[1:0]);
                    `PVP_OFF_LINE: line_len <=
                        merge16(line_len, wlo, w_strb[1:0]);
                    `PVP_OFF_FRAME: frame_lines <=
                        merge16(frame_lines, wlo, w_strb[1:0]);
                    default: ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Sticky status, cleared by writing ones; a new event wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_ovr  <= 1'b0;
            st_udr  <= 1'b0;
            st_done <= 1'b0;
        end else begin
            st_ovr  <= (st_ovr & ~(wr_stat & w_data[`PVP_ST_OVR])) | set_ovr;
            st_udr  <= (st_udr & ~(wr_stat & w_data[`PVP_ST_UDR])) | set_udr;
            st_done <= (st_done & ~(wr_stat & w_data[`PVP_ST_DONE])) |
                       set_done;
        end
    end

    reg  [31:0] rd_mux;
    reg         rd_hit;

    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PVP_OFF_CTRL:  rd_mux = {21'h0, port_control_setting};
            `PVP_OFF_DELAY: rd_mux = {16'h0, start_delay_setting};
            `PVP_OFF_COUNT: rd_mux = {16'h0, transfer_count_setting};
            `PVP_OFF_STAT:  rd_mux = {26'h0, state != ST_IDLE, last_f,
                                      aligned, st_done, st_udr, st_ovr};
            `PVP_OFF_LINE:  rd_mux = {16'h0, line_len};
            `PVP_OFF_FRAME: rd_mux = {16'h0, frame_lines};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PVP_RESP_OKAY;
        end else begin
            s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~s_axi_rready);
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `PVP_RESP_OKAY : `PVP_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ==== core/pvp_regs.vh ====
`ifndef PVP_REGS_VH
`define PVP_REGS_VH

// Register byte offsets
`define PVP_OFF_CTRL    8'h00
`define PVP_OFF_DELAY   8'h04
`define PVP_OFF_COUNT   8'h08
`define PVP_OFF_STAT    8'h0c
`define PVP_OFF_LINE    8'h10
`define PVP_OFF_FRAME   8'h14

// Control fields
`define PVP_CTRL_EN     0
`define PVP_CTRL_SUB    1
`define PVP_CTRL_ITU    3
`define PVP_CTRL_ITUM   4
`define PVP_CTRL_DLEN   6
`define PVP_CTRL_NFS    9
`define PVP_CTRL_W      11

// Status fields
`define PVP_ST_OVR      0
`define PVP_ST_UDR      1
`define PVP_ST_DONE     2
`define PVP_ST_ALIGN    3
`define PVP_ST_FIELD    4
`define PVP_ST_BUSY     5

// Reset values
`define PVP_RST_CTRL    11'h000
`define PVP_RST_DELAY   16'h0000
`define PVP_RST_COUNT   16'h0000
`define PVP_RST_LINE    16'h0010
`define PVP_RST_FRAME   16'h0004

// Submode and ITU mode codes
`define PVP_SUB_IN      2'h0
`define PVP_SUB_CAP     2'h1
`define PVP_SUB_OUT     2'h2
`define PVP_ITU_ACT     2'h0
`define PVP_ITU_VBI     2'h1
`define PVP_ITU_FULL    2'h2

// Bus responses
`define PVP_RESP_OKAY   2'h0
`define PVP_RESP_SLVERR 2'h2

`endif

// ==== verification/pvp_port_sva.sv ====
`timescale 1ns/1ps
`include "pvp_regs.vh"
module pvp_port_sva #(
    parameter DW = 16
) (
    // Clock and reset
    input logic          aclk,
    input logic          aresetn,
    // Register bus
    input logic          s_axi_awvalid,
    input logic          s_axi_awready,
    input logic          s_axi_wvalid,
    input logic          s_axi_wready,
    input logic          s_axi_bvalid,
    input logic          s_axi_arvalid,
    input logic          s_axi_arready,
    input logic          s_axi_rvalid,
    input logic [1:0]    s_axi_rresp,
    input logic [31:0]   s_axi_rdata,
    // Port and stream
    input logic [DW-1:0] rx_tdata,
    input logic          rx_tvalid,
    input logic          rx_tready,
    input logic          frame_sync_one_out,
    input logic          frame_sync_one_oe,
    input logic          data_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (!s_axi_bvalid &&
        s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response not two edges after request");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one edge after request");
    a_aw_busy: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready while request held");
    a_slverr_data: assert property (s_axi_rvalid &&
        s_axi_rresp == `PVP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    a_rx_hold: assert property (
        rx_tvalid && !rx_tready |=> rx_tvalid && $stable(rx_tdata))
        else $error("waiting word changed or vanished");
    a_rx_gap: assert property (
        rx_tvalid && rx_tready && !$past(rx_tvalid) |=> !rx_tvalid [*8])
        else $error("word repeated within one port clock");
    a_fs_pulse: assert property (
        $rose(frame_sync_one_out) |-> frame_sync_one_out [*8])
        else $error("generated sync shorter than a port clock");
    a_fs_oe: assert property (
        frame_sync_one_out |-> frame_sync_one_oe)
        else $error("sync driven high without its enable");
    a_data_oe: assert property (
        data_oe |-> frame_sync_one_oe)
        else $error("data driven while syncs are inputs");

    cover property (rx_tvalid && rx_tready);
    cover property ($rose(frame_sync_one_out));
    cover property (s_axi_rvalid && s_axi_rresp == `PVP_RESP_SLVERR);
endmodule

bind pvp_port pvp_port_sva #(.DW(DW)) u_pvp_port_sva (.*);

// ==== verification/pvp_port_tb.sv ====
`timescale 1ns/1ps
`include "pvp_regs.vh"
module pvp_port_tb;
    logic        aclk, awready, wready, bvalid, arready, rvalid, rx_v;
    logic        pclk, fs1, fo1, fe1, fo2, fe2, doe;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        rx_r = 1'b1, tx_v = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] src_d, dout, rx_d, tx_d = 16'h0000;
    logic [15:0] got[$];
    int          n_fail = 0, compares = 0, saw_fs;
    wire         fs1_pin = fe1 ? fo1 : fs1;
    wire         fs2_pin = fe2 ? fo2 : 1'b0;
    wire  [15:0] data_pin = doe ? dout : src_d;

    pvp_src u_pvp_src (.port_input_clock(pclk), .frame_sync_one(fs1),
        .data(src_d));
    pvp_port u_pvp_port (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_input_clock(pclk),
        .frame_sync_one_in(fs1_pin), .frame_sync_one_out(fo1),
        .frame_sync_one_oe(fe1), .frame_sync_two_in(fs2_pin),
        .frame_sync_two_out(fo2), .frame_sync_two_oe(fe2),
        .frame_sync_three_in(1'b0), .frame_sync_three_out(),
        .frame_sync_three_oe(), .data_in(data_pin), .data_out(dout),
        .data_oe(doe), .rx_tdata(rx_d), .rx_tvalid(rx_v), .rx_tready(rx_r),
        .tx_tdata(tx_d), .tx_tvalid(tx_v), .tx_tready());

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_v && rx_r)
            got.push_back(rx_d);
        if (fo1)
            saw_fs = 1;
    end

    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Either channel may be taken first; each drops on its own edge
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic cfg(input logic [31:0] c, input int dl, input int cn);
        got.delete();
        wr(`PVP_OFF_DELAY, dl);
        wr(`PVP_OFF_COUNT, cn);
        wr(`PVP_OFF_CTRL, c);
    endtask

    task automatic t_regs;
        rd(`PVP_OFF_LINE);
        chk("line reset", {16'h0, `PVP_RST_LINE}, d);
        rd(`PVP_OFF_FRAME);
        chk("frame reset", {16'h0, `PVP_RST_FRAME}, d);
        wr(8'h18, 32'h1);
        chk("unmapped bresp", `PVP_RESP_SLVERR, r);
        rd(8'h18);
        chk("unmapped rresp", `PVP_RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        $display("test regs done");
    endtask
    task automatic t_input;
        cfg(32'h1c1, 2, 3);
        u_pvp_src.frame(7, 16'h8a10);
        repeat (20) @(posedge aclk);
        chk("word count", 3, got.size());
        for (int i = 0; i < 3; i++)
            chk("word", 16'h8a13 + i, got[i]);
        rd(`PVP_OFF_STAT);
        chk("done", 1'b1, d[`PVP_ST_DONE]);
        wr(`PVP_OFF_CTRL, 32'h0);
        $display("test input done");
    endtask
    task automatic t_narrow;
        rx_r <= 1'b0;
        cfg(32'h1, 0, 3);
        u_pvp_src.frame(5, 16'h12fe);
        @(posedge aclk);
        rx_r <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("held words", 1, got.size());
        chk("narrow word", 16'h00ff, got[0]);
        rd(`PVP_OFF_STAT);
        chk("overrun", 1'b1, d[`PVP_ST_OVR]);
        wr(`PVP_OFF_CTRL, 32'h0);
        $display("test narrow done");
    endtask
    task automatic t_modes;
        tx_d <= 16'h5a5a;
        tx_v <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            saw_fs = 0;
            cfg(32'h1c1 | (s << 1), 0, 2);
            u_pvp_src.frame(40, 16'h0);
            chk("sync and data enables", {s > 0, s > 1}, {fe1, doe});
            chk("sync generated", s > 0, saw_fs);
            if (s == 1)
                chk("vertical sync enable", 1'b1, fe2);
            if (s == 2)
                chk("sent word", 16'h5a5a, dout);
            wr(`PVP_OFF_CTRL, 32'h0);
        end
        $display("test modes done");
    endtask
    task automatic t_video;
        cfg(32'h9, 0, 1);
        u_pvp_src.vline(8'h80, 2);
        u_pvp_src.vline(8'h80, 2);
        u_pvp_src.vline(8'h90, 1);
        repeat (20) @(posedge aclk);
        chk("video words", 2, got.size());
        chk("video word 0", 16'h0040, got[0]);
        chk("video word 1", 16'h0041, got[1]);
        wr(`PVP_OFF_CTRL, 32'h0);
        $display("test video done");
    endtask

    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_input();
        t_narrow();
        t_modes();
        t_video();
        test_done();
    end
    initial begin
        #200000;
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
endmodule

// ==== verification/pvp_src.sv ====
`timescale 1ns/1ps
module pvp_src (
    // Link pins toward the port
    output logic        port_input_clock,
    output logic        frame_sync_one,
    output logic [15:0] data
);
    initial begin
        port_input_clock = 1'b0;
        frame_sync_one = 1'b0;
        data = 16'h0000;
    end
    // Clock stands still between frames; word k is on the pins at edge k
    task automatic frame(input int n, input logic [15:0] base);
        #3;
        for (int i = 0; i < n; i++) begin
            data = base + 16'(i);
            frame_sync_one = 1'b1;
            #80;
            port_input_clock = 1'b1;
            #80;
            port_input_clock = 1'b0;
        end
        frame_sync_one = 1'b0;
        // Released bus shows the inverse so a stale sample cannot match
        data = ~data;
    endtask
    // Timing code: ones, zero, zero, status word; then n samples
    task automatic vline(input logic [7:0] xy, input int n);
        #3;
        for (int i = -4; i < n; i++) begin
            data = (i == -4) ? 16'h00ff : (i == -1) ? {8'h00, xy} :
                   (i < 0) ? 16'h0000 : 16'h0040 + 16'(i);
            #80 port_input_clock = 1'b1;
            #80 port_input_clock = 1'b0;
        end
    endtask
endmodule
